//--- hw/dlt_cfg.svh
// Constants for the dual legacy counter/timer block.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef DLT_CFG_SVH
`define DLT_CFG_SVH

// Register indices; the byte address is four times the index
`define DLT_IDX_RUN_FLAG   8'h88
`define DLT_IDX_MODE       8'h89
`define DLT_IDX_T0_LOW     8'h8A
`define DLT_IDX_T1_LOW     8'h8B
`define DLT_IDX_T0_HIGH    8'h8C
`define DLT_IDX_T1_HIGH    8'h8D
`define DLT_IDX_CLK_SEL    8'h8E
`define DLT_IDX_EXT_CFG    8'h90

// Clock select fields
`define DLT_CKS_HI_SYS     5
`define DLT_CKS_LO_SYS     4
`define DLT_CKS_T1_SYS     3
`define DLT_CKS_T0_SYS     2
`define DLT_CKS_W          6

// Run/flag register fields
`define DLT_RF_TF1         7
`define DLT_RF_TR1         6
`define DLT_RF_TF0         5
`define DLT_RF_TR0         4

// Extra configuration fields
`define DLT_EC_POL0        0
`define DLT_EC_POL1        1
`define DLT_EC_IEN0        2
`define DLT_EC_IEN1        3
`define DLT_EC_W           4

// Prescale terminal counts (divide minus one)
`define DLT_DIV12_LAST     6'h0B
`define DLT_DIV4_LAST      6'h03
`define DLT_DIV48_LAST     6'h2F
`define DLT_EXT_DIV_LAST   3'h7

`define DLT_RESET_BYTE     8'h00
`define DLT_BYTE_ONES      8'hFF
`define DLT_LOW5_ONES      5'h1F
`define DLT_RESP_OKAY      2'h0
`define DLT_RESP_SLVERR    2'h2

`endif

//--- hw/dlt_pkg.sv
// Types shared by the dual legacy counter/timer block.
// Assumes dlt_cfg.svh is on the include path.
`default_nettype none
package dlt_pkg;
  typedef enum logic [1:0] {
    DLT_MODE13 = 2'b00,
    DLT_MODE16 = 2'b01,
    DLT_MODE8AR = 2'b10,
    DLT_MODESPLIT = 2'b11
  } dlt_mode_t;

  // One timer's nibble of the mode register
  typedef struct packed {
    logic      gate_en;
    logic      count_select;
    dlt_mode_t mode;
  } dlt_tctl_t;
endpackage
`default_nettype wire

//--- hw/dlt_timers.sv
// Two 8-bit-byte legacy counter/timers with their clock control register.
// Assumes an AXI4-Lite master on sys_clk; pins are asynchronous.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "dlt_cfg.svh"

module dlt_pin_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level,
  output logic      fall,
  output logic      rise
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_r <= s3_r;
    end
  end

  assign level = level_r;
  assign fall  = level_r & ~s2_r & ~s3_r;
  assign rise  = ~level_r & s2_r & s3_r;
endmodule

module dlt_timers
  import dlt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]    s_axi_awprot,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]    s_axi_arprot,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          timer0_count_pin,
  input  wire logic          timer1_count_pin,
  input  wire logic          gate_input_zero,
  input  wire logic          gate_input_one,
  input  wire logic          ext_clk_pin,
  input  wire logic          irq_ack0,
  input  wire logic          irq_ack1,
  output logic               timer0_irq,
  output logic               timer1_irq,
  output logic               timer1_ovf_pulse,
  output logic               third_timer_high_sysclk,
  output logic               third_timer_low_sysclk
);
  // The decode needs index bits 9:2 and a zero check above them
  if (ADDR_W < 10 || ADDR_W > 32)
    $error("dlt_timers: ADDR_W must be 10 to 32");

  logic [`DLT_CKS_W-1:0] timer_clock_select_r;
  logic [7:0]            timer_run_flag_reg_r;
  logic [7:0]            timer_mode_reg_r;
  logic [7:0]            timer0_low_byte_r;
  logic [7:0]            timer0_high_byte_r;
  logic [7:0]            timer1_low_byte_r;
  logic [7:0]            timer1_high_byte_r;
  logic [`DLT_EC_W-1:0]  ext_input_config_r;
  logic                  awready_r;
  logic                  wready_r;
  logic                  bvalid_r;
  logic [1:0]            bresp_r;
  logic                  arready_r;
  logic                  rvalid_r;
  logic [1:0]            rresp_r;
  logic [31:0]           rdata_r;
  logic                  aw_hold_r;
  logic                  w_hold_r;
  logic [ADDR_W-1:0]     waddr_r;
  logic [7:0]            wbyte_r;
  logic                  wlane_r;
  logic [5:0]            presc_cnt_r;
  logic [2:0]            ext_cnt_r;
  logic                  t0_irq_r;
  logic                  t1_irq_r;
  logic                  t1_ovf_r;
  logic                  hi_sys_r;
  logic                  lo_sys_r;

  dlt_tctl_t t0_ctl;
  dlt_tctl_t t1_ctl;
  logic      do_write;
  logic      wr_ok;
  logic      wr_run_flag;
  logic      wr_mode;
  logic      wr_t0l;
  logic      wr_t0h;
  logic      wr_t1l;
  logic      wr_t1h;
  logic      wr_cks;
  logic      wr_ext;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic       rd_ok;
  logic [7:0] rd_byte;
  logic t0_fall;
  logic t1_fall;
  logic g0_level;
  logic g1_level;
  logic ext_rise;
  logic [5:0] presc_last;
  logic presc_tick;
  logic split;
  logic tr0;
  logic tr1;
  logic g0_ok;
  logic g1_ok;
  logic t0_tick;
  logic t1_tick;
  logic t0_inc;
  logic t1_inc;
  logic th0_inc;
  logic th0_ovf;
  logic [16:0] t0_step;
  logic [16:0] t1_step;
  logic ovf0;
  logic ovf1;
  logic set_tf0;
  logic set_tf1;
  logic tf0_nxt;
  logic tf1_nxt;

  dlt_pin_sync u_t0_pin (
    .clk    (sys_clk),
    .resetn (resetn),
    .pin    (timer0_count_pin),
    .level  (),
    .fall   (t0_fall),
    .rise   ()
  );
  dlt_pin_sync u_t1_pin (
    .clk    (sys_clk),
    .resetn (resetn),
    .pin    (timer1_count_pin),
    .level  (),
    .fall   (t1_fall),
    .rise   ()
  );
  dlt_pin_sync u_timer0_gate_en (
    .clk    (sys_clk),
    .resetn (resetn),
    .pin    (gate_input_zero),
    .level  (g0_level),
    .fall   (),
    .rise   ()
  );
  dlt_pin_sync u_timer1_gate_en (
    .clk    (sys_clk),
    .resetn (resetn),
    .pin    (gate_input_one),
    .level  (g1_level),
    .fall   (),
    .rise   ()
  );
  dlt_pin_sync u_ext (
    .clk    (sys_clk),
    .resetn (resetn),
    .pin    (ext_clk_pin),
    .level  (),
    .fall   (),
    .rise   (ext_rise)
  );

  // One step of a count; result is {overflow, high byte, low byte}
  function automatic logic [16:0] dlt_step(input dlt_mode_t m,
                                           input logic [15:0] c,
                                           input logic inc);
    logic [13:0] s13;
    logic [16:0] r;
    s13 = 14'({1'b0, c[15:8], c[4:0]}) + 14'h0001;
    r = {1'b0, c};
    if (inc)
    begin
      unique case (m)
        DLT_MODE13:
          r = {s13[13], s13[12:5], c[7:5], s13[4:0]};
        DLT_MODE16:
          r = {1'b0, c} + 17'h0_0001;
        DLT_MODE8AR:
          if (c[7:0] == `DLT_BYTE_ONES)
            r = {1'b1, c[15:8], c[15:8]};
          else
            r = {1'b0, c[15:8], c[7:0] + 8'h01};
        DLT_MODESPLIT:
          r = {c[7:0] == `DLT_BYTE_ONES, c[15:8], c[7:0] + 8'h01};
      endcase
    end
    return r;
  endfunction

  // Register decode
  assign wr_idx = waddr_r[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_ok = (waddr_r[1:0] == 2'b00) &&
                 (ADDR_W == 10 || waddr_r[ADDR_W-1:10] == '0) &&
                 (wr_idx == `DLT_IDX_RUN_FLAG || wr_idx == `DLT_IDX_MODE ||
                  wr_idx == `DLT_IDX_T0_LOW || wr_idx == `DLT_IDX_T1_LOW ||
                  wr_idx == `DLT_IDX_T0_HIGH || wr_idx == `DLT_IDX_T1_HIGH ||
                  wr_idx == `DLT_IDX_CLK_SEL || wr_idx == `DLT_IDX_EXT_CFG);
  assign wr_run_flag = do_write & wlane_r & (wr_idx == `DLT_IDX_RUN_FLAG);
  assign wr_mode = do_write & wlane_r & (wr_idx == `DLT_IDX_MODE);
  assign wr_t0l = do_write & wlane_r & (wr_idx == `DLT_IDX_T0_LOW);
  assign wr_t0h = do_write & wlane_r & (wr_idx == `DLT_IDX_T0_HIGH);
  assign wr_t1l = do_write & wlane_r & (wr_idx == `DLT_IDX_T1_LOW);
  assign wr_t1h = do_write & wlane_r & (wr_idx == `DLT_IDX_T1_HIGH);
  assign wr_cks = do_write & wlane_r & (wr_idx == `DLT_IDX_CLK_SEL);
  assign wr_ext = do_write & wlane_r & (wr_idx == `DLT_IDX_EXT_CFG);

  always_comb
  begin
    rd_ok = (s_axi_araddr[1:0] == 2'b00) &&
            (ADDR_W == 10 || s_axi_araddr[ADDR_W-1:10] == '0);
    unique case (rd_idx)
      `DLT_IDX_RUN_FLAG: rd_byte = timer_run_flag_reg_r;
      `DLT_IDX_MODE:     rd_byte = timer_mode_reg_r;
      `DLT_IDX_T0_LOW:   rd_byte = timer0_low_byte_r;
      `DLT_IDX_T0_HIGH:  rd_byte = timer0_high_byte_r;
      `DLT_IDX_T1_LOW:   rd_byte = timer1_low_byte_r;
      `DLT_IDX_T1_HIGH:  rd_byte = timer1_high_byte_r;
      `DLT_IDX_CLK_SEL:  rd_byte = {2'b00, timer_clock_select_r};
      `DLT_IDX_EXT_CFG:  rd_byte = {4'h0, ext_input_config_r};
      default:
      begin
        rd_byte = `DLT_RESET_BYTE;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `DLT_RESP_OKAY;
      waddr_r   <= '0;
      wbyte_r   <= `DLT_RESET_BYTE;
      wlane_r   <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && awready_r)
      begin
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
        waddr_r   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r)
      begin
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
        wbyte_r  <= s_axi_wdata[7:0];
        wlane_r  <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? `DLT_RESP_OKAY : `DLT_RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `DLT_RESP_OKAY;
      rdata_r   <= '0;
    end
    else if (s_axi_arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= rd_ok ? `DLT_RESP_OKAY : `DLT_RESP_SLVERR;
      rdata_r   <= {24'h00_0000, rd_byte};
    end
    else if (rvalid_r && s_axi_rready)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // Configuration registers; bits 7:6 of clock select are not stored
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      timer_clock_select_r <= '0;
      timer_mode_reg_r     <= `DLT_RESET_BYTE;
      ext_input_config_r   <= '0;
    end
    else
    begin
      if (wr_cks)
        timer_clock_select_r <= wbyte_r[`DLT_CKS_W-1:0];
      if (wr_mode)
        timer_mode_reg_r <= wbyte_r;
      if (wr_ext)
        ext_input_config_r <= wbyte_r[`DLT_EC_W-1:0];
    end
  end

  // Prescaler; a field change restarts nothing, so the first period may be short
  always_comb
  begin
    unique case (timer_clock_select_r[1:0])
      2'b00:   presc_last = `DLT_DIV12_LAST;
      2'b01:   presc_last = `DLT_DIV4_LAST;
      default: presc_last = `DLT_DIV48_LAST;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      presc_cnt_r <= '0;
      ext_cnt_r   <= '0;
    end
    else
    begin
      presc_cnt_r <= (presc_cnt_r >= presc_last) ? 6'h00
                                                 : presc_cnt_r + 6'h01;
      if (ext_rise)
        ext_cnt_r <= ext_cnt_r + 3'h1;
    end
  end

  assign presc_tick = (timer_clock_select_r[1:0] == 2'b11) ?
                      (ext_rise && ext_cnt_r == `DLT_EXT_DIV_LAST) :
                      (presc_cnt_r == presc_last);

  // Count enables
  assign t0_ctl = dlt_tctl_t'(timer_mode_reg_r[3:0]);
  assign t1_ctl = dlt_tctl_t'(timer_mode_reg_r[7:4]);
  assign split  = (t0_ctl.mode == DLT_MODESPLIT);
  assign tr0    = timer_run_flag_reg_r[`DLT_RF_TR0];
  assign tr1    = timer_run_flag_reg_r[`DLT_RF_TR1];
  assign g0_ok  = ~t0_ctl.gate_en |
                  (g0_level == ext_input_config_r[`DLT_EC_POL0]);
  assign g1_ok  = ~t1_ctl.gate_en |
                  (g1_level == ext_input_config_r[`DLT_EC_POL1]);
  assign t0_tick = t0_ctl.count_select ? t0_fall :
                   (timer_clock_select_r[`DLT_CKS_T0_SYS] | presc_tick);
  assign t1_tick = (t1_ctl.count_select && !split) ? t1_fall :
                   (timer_clock_select_r[`DLT_CKS_T1_SYS] | presc_tick);
  assign t0_inc = tr0 & g0_ok & t0_tick;
  assign t1_inc = (split ? 1'b1 : (tr1 & g1_ok)) & t1_tick &
                  (t1_ctl.mode != DLT_MODESPLIT);
  assign th0_inc = split & tr1 &
                   (timer_clock_select_r[`DLT_CKS_T0_SYS] | presc_tick);
  assign th0_ovf = th0_inc & (timer0_high_byte_r == `DLT_BYTE_ONES);
  assign t0_step = dlt_step(t0_ctl.mode,
                            {timer0_high_byte_r, timer0_low_byte_r}, t0_inc);
  assign t1_step = dlt_step(t1_ctl.mode,
                            {timer1_high_byte_r, timer1_low_byte_r}, t1_inc);
  assign ovf0 = t0_step[16];
  assign ovf1 = t1_step[16];

  // Count bytes; a software write to a byte wins over its increment
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      timer0_low_byte_r  <= `DLT_RESET_BYTE;
      timer0_high_byte_r <= `DLT_RESET_BYTE;
      timer1_low_byte_r  <= `DLT_RESET_BYTE;
      timer1_high_byte_r <= `DLT_RESET_BYTE;
    end
    else
    begin
      timer0_low_byte_r <= wr_t0l ? wbyte_r : t0_step[7:0];
      if (wr_t0h)
        timer0_high_byte_r <= wbyte_r;
      else if (split)
        timer0_high_byte_r <= timer0_high_byte_r + {7'h00, th0_inc};
      else
        timer0_high_byte_r <= t0_step[15:8];
      timer1_low_byte_r  <= wr_t1l ? wbyte_r : t1_step[7:0];
      timer1_high_byte_r <= wr_t1h ? wbyte_r : t1_step[15:8];
    end
  end

  // Flags: a hardware set wins over a software clear or a vector ack
  assign set_tf0 = ovf0;
  assign set_tf1 = split ? th0_ovf : ovf1;
  assign tf0_nxt = set_tf0 | (~irq_ack0 & (wr_run_flag ? wbyte_r[`DLT_RF_TF0]
                   : timer_run_flag_reg_r[`DLT_RF_TF0]));
  assign tf1_nxt = set_tf1 | (~irq_ack1 & (wr_run_flag ? wbyte_r[`DLT_RF_TF1]
                   : timer_run_flag_reg_r[`DLT_RF_TF1]));

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      timer_run_flag_reg_r <= `DLT_RESET_BYTE;
    else
    begin
      // Run bits only gate counting; the count is left alone
      if (wr_run_flag)
        timer_run_flag_reg_r <= wbyte_r;
      timer_run_flag_reg_r[`DLT_RF_TF0] <= tf0_nxt;
      timer_run_flag_reg_r[`DLT_RF_TF1] <= tf1_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      t0_irq_r <= 1'b0;
      t1_irq_r <= 1'b0;
      t1_ovf_r <= 1'b0;
      hi_sys_r <= 1'b0;
      lo_sys_r <= 1'b0;
    end
    else
    begin
      t0_irq_r <= tf0_nxt & ext_input_config_r[`DLT_EC_IEN0];
      t1_irq_r <= tf1_nxt & ext_input_config_r[`DLT_EC_IEN1];
      t1_ovf_r <= ovf1;
      hi_sys_r <= timer_clock_select_r[`DLT_CKS_HI_SYS];
      lo_sys_r <= timer_clock_select_r[`DLT_CKS_LO_SYS];
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign timer0_irq    = t0_irq_r;
  assign timer1_irq    = t1_irq_r;
  assign timer1_ovf_pulse        = t1_ovf_r;
  assign third_timer_high_sysclk = hi_sys_r;
  assign third_timer_low_sysclk  = lo_sys_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  cks_top_zero_a: assert property (
    (s_axi_arvalid && arready_r && rd_idx == `DLT_IDX_CLK_SEL)
    |=> s_axi_rvalid && s_axi_rdata[7:6] == 2'b00)
    else $error("clock select top bits not zero");
  t0_sysclk_a: assert property (
    (tr0 && !t0_ctl.gate_en && !t0_ctl.count_select &&
     t0_ctl.mode == DLT_MODE13 && !wr_t0l && !wr_t0h &&
     timer_clock_select_r[`DLT_CKS_T0_SYS])
    |=> {timer0_high_byte_r, timer0_low_byte_r[4:0]} ==
        13'($past({timer0_high_byte_r, timer0_low_byte_r[4:0]}) + 13'h0001))
    else $error("timer 0 missed a system clock count");
  presc_gap_a: assert property (
    (presc_tick && timer_clock_select_r[1:0] == 2'b00)
    |=> (!presc_tick || timer_clock_select_r[1:0] != 2'b00) [*8])
    else $error("prescale tick too early");
  wrap13_a: assert property (
    (t0_ctl.mode == DLT_MODE13 && t0_inc && !wr_t0l && !wr_t0h &&
     timer0_high_byte_r == `DLT_BYTE_ONES &&
     timer0_low_byte_r[4:0] == `DLT_LOW5_ONES)
    |=> timer_run_flag_reg_r[`DLT_RF_TF0] && timer0_high_byte_r == 8'h00
        && timer0_low_byte_r[4:0] == 5'h00)
    else $error("13-bit wrap did not set the flag");
  reload_a: assert property (
    (t1_ctl.mode == DLT_MODE8AR && t1_inc && !split && !wr_t1l && !wr_t1h &&
     timer1_low_byte_r == `DLT_BYTE_ONES)
    |=> timer1_low_byte_r == $past(timer1_high_byte_r) &&
        $stable(timer1_high_byte_r) && timer_run_flag_reg_r[`DLT_RF_TF1])
    else $error("auto-reload wrong");
  gate_block_a: assert property (
    (t0_ctl.gate_en && g0_level != ext_input_config_r[`DLT_EC_POL0])
    |-> !t0_inc)
    else $error("timer 0 counted with gate closed");
  run_keeps_a: assert property (
    $rose(tr0) && !split |-> $stable({timer0_high_byte_r, timer0_low_byte_r}))
    else $error("setting run changed the count");
  pin_count_a: assert property (
    (t0_ctl.count_select && tr0 && g0_ok) |-> (t0_inc == t0_fall))
    else $error("counter mode not tied to pin edge");
  split_th0_a: assert property (
    (split && th0_inc && !wr_t0h && timer0_high_byte_r == `DLT_BYTE_ONES)
    |=> timer_run_flag_reg_r[`DLT_RF_TF1] && timer0_high_byte_r == 8'h00)
    else $error("split high byte overflow lost");
  t1_mode3_a: assert property (
    (t1_ctl.mode == DLT_MODESPLIT && !wr_t1l && !wr_t1h)
    |=> $stable({timer1_high_byte_r, timer1_low_byte_r}))
    else $error("timer 1 moved in mode 3");
  ack_clear_a: assert property (
    (irq_ack0 && !set_tf0) |=> !timer_run_flag_reg_r[`DLT_RF_TF0])
    else $error("vector ack did not clear flag");

  cover_wrap_c: cover property (t0_ctl.mode == DLT_MODE13 && ovf0);
  cover_reload_c: cover property (t1_ctl.mode == DLT_MODE8AR && ovf1);
  cover_split_c: cover property (split && th0_ovf);
  cover_ext_c: cover property (presc_tick && timer_clock_select_r[1:0] == 2'b11);
endmodule

`default_nettype wire

//--- tb/dlt_pin_model.sv
// Far-side pin model: count pins, gate pins and an external clock.
// Assumes the bench calls its tasks; count pin levels stand at least 3 cycles each.
`timescale 1ns/1ps
`default_nettype none

module dlt_pin_model (
  input  wire logic clk,
  output var logic  t0_pin,
  output var logic  t1_pin,
  output var logic  g0_pin,
  output var logic  g1_pin,
  output var logic  ext_pin
);
  initial
  begin
    t0_pin = 1'b1;
    t1_pin = 1'b1;
    g0_pin = 1'b1;
    g1_pin = 1'b1;
    ext_pin = 1'b0;
  end

  logic ext_half = 1'b0;

  // Free-running source at a quarter of the system rate; each level
  // stands two cycles so the three-stage synchroniser sees it settle
  always @(posedge clk)
  begin
    ext_half <= ~ext_half;
    if (ext_half)
      ext_pin <= ~ext_pin;
  end

  task automatic gate(input bit v0, input bit v1);
    @(posedge clk);
    g0_pin <= v0;
    g1_pin <= v1;
  endtask

  // Three cycles a level, so a two-sample detector never misses an edge
  task automatic fall(input bit sel, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (sel)
        t1_pin <= 1'b0;
      else
        t0_pin <= 1'b0;
      repeat (3) @(posedge clk);
      if (sel)
        t1_pin <= 1'b1;
      else
        t0_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the dual counter/timer block.
// Assumes dlt_pin_model on the far side and dlt_cfg.svh on the path.
`timescale 1ns/1ps
`default_nettype none
`include "dlt_cfg.svh"

module testbench;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        irq_ack0 = 1'b0;
  logic        irq_ack1 = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, timer0_irq, timer1_irq, ext_clk_pin;
  logic        timer1_ovf_pulse;
  logic        third_timer_high_sysclk, third_timer_low_sysclk;
  logic        timer0_count_pin, timer1_count_pin;
  logic        gate_input_zero, gate_input_one;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_v;
  logic [31:0] seed = 32'h0000_E3AB;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n_ovf = 0;

  dlt_timers uut (
    .sys_clk, .resetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer0_count_pin, .timer1_count_pin, .gate_input_zero,
    .gate_input_one, .ext_clk_pin, .irq_ack0, .irq_ack1, .timer0_irq,
    .timer1_irq, .timer1_ovf_pulse, .third_timer_high_sysclk,
    .third_timer_low_sysclk);

  dlt_pin_model pm (
    .clk(sys_clk), .t0_pin(timer0_count_pin), .t1_pin(timer1_count_pin),
    .g0_pin(gate_input_zero), .g1_pin(gate_input_one),
    .ext_pin(ext_clk_pin));

  always #25 sys_clk = ~sys_clk;

  // Overflow pulses offered to other peripherals, tallied for mode 2
  always @(posedge sys_clk)
    if (timer1_ovf_pulse === 1'b1)
      n_ovf <= n_ovf + 1;

  // A hang ends here rather than running on
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wrap_up();
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx);
    @(posedge sys_clk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  initial
  begin
    int n;
    int v;
    bit f;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`DLT_IDX_CLK_SEL);
    chk("clk_sel reset", rd_v, 32'h0000_0000);
    wr(`DLT_IDX_CLK_SEL, 8'hFF);
    rd(`DLT_IDX_CLK_SEL);
    chk("clk_sel", rd_v, 32'h0000_003F);
    chk("hi sysclk", third_timer_high_sysclk, 32'h0000_0001);
    chk("lo sysclk", third_timer_low_sysclk, 32'h0000_0001);
    wr(8'h00, 8'h55);
    chk("unmapped bresp", resp, 32'h0000_0002);
    wr(`DLT_IDX_CLK_SEL, 8'h04);
    wr(`DLT_IDX_EXT_CFG, 8'h04);
    wr(`DLT_IDX_MODE, 8'h60);
    wr(`DLT_IDX_T0_HIGH, 8'hFF);
    wr(`DLT_IDX_T0_LOW, 8'h1F);
    wr(`DLT_IDX_RUN_FLAG, 8'h10);
    n = 0;
    while (!timer0_irq && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("t0 irq", timer0_irq, 32'h0000_0001);
    rd(`DLT_IDX_RUN_FLAG);
    chk("t0 flag", rd_v, 32'h0000_0030);
    irq_ack0 <= 1'b1;
    @(posedge sys_clk);
    irq_ack0 <= 1'b0;
    rd(`DLT_IDX_RUN_FLAG);
    chk("t0 flag ack", rd_v, 32'h0000_0010);
    wr(`DLT_IDX_RUN_FLAG, 8'h00);
    // Mode 2 counter on timer 1 with a random number of pin edges
    wr(`DLT_IDX_T1_LOW, 8'hFE);
    wr(`DLT_IDX_T1_HIGH, 8'hA5);
    wr(`DLT_IDX_RUN_FLAG, 8'h40);
    n = 1 + rnd() % 5;
    v = 32'h0000_00FE;
    f = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      f |= (v == 32'h0000_00FF);
      v = (v == 32'h0000_00FF) ? 32'h0000_00A5 : v + 1;
    end
    pm.fall(1'b1, n);
    repeat (6) @(posedge sys_clk);
    rd(`DLT_IDX_T1_LOW);
    chk("t1 low", rd_v, v);
    rd(`DLT_IDX_T1_HIGH);
    chk("t1 reload", rd_v, 32'h0000_00A5);
    rd(`DLT_IDX_RUN_FLAG);
    chk("t1 flag", rd_v, {f, 7'h40});
    chk("t1 ovf pulses", n_ovf, f);
    // Gated 16-bit counter on timer 0, carry into the high byte
    wr(`DLT_IDX_MODE, 8'h6D);
    wr(`DLT_IDX_T0_LOW, 8'hFF);
    wr(`DLT_IDX_T0_HIGH, 8'h12);
    wr(`DLT_IDX_RUN_FLAG, 8'h50);
    pm.fall(1'b0, 3);
    repeat (6) @(posedge sys_clk);
    rd(`DLT_IDX_T0_LOW);
    chk("t0 gated", rd_v, 32'h0000_00FF);
    pm.gate(1'b0, 1'b1);
    repeat (4) @(posedge sys_clk);
    pm.fall(1'b0, 2);
    repeat (6) @(posedge sys_clk);
    rd(`DLT_IDX_T0_LOW);
    chk("t0 low", rd_v, 32'h0000_0001);
    rd(`DLT_IDX_T0_HIGH);
    chk("t0 high", rd_v, 32'h0000_0013);
    // Split mode: high byte on ext/8, timer 1 parked in mode 3
    wr(`DLT_IDX_RUN_FLAG, 8'h00);
    wr(`DLT_IDX_CLK_SEL, 8'h03);
    wr(`DLT_IDX_EXT_CFG, 8'h08);
    wr(`DLT_IDX_MODE, 8'h33);
    wr(`DLT_IDX_T0_HIGH, 8'hFE);
    wr(`DLT_IDX_RUN_FLAG, 8'h40);
    rd(`DLT_IDX_RUN_FLAG);
    chk("split early", rd_v, 32'h0000_0040);
    repeat (120) @(posedge sys_clk);
    rd(`DLT_IDX_RUN_FLAG);
    chk("split flag", rd_v, 32'h0000_00C0);
    chk("t1 irq", timer1_irq, 32'h0000_0001);
    rd(`DLT_IDX_T0_LOW);
    chk("split low held", rd_v, 32'h0000_0001);
    rd(`DLT_IDX_T1_LOW);
    chk("t1 parked", rd_v, v);
    wrap_up();
  end
endmodule

`default_nettype wire
